/* snmcp_mem.sv */
// Package of shared constants and the byte-wide memory array of the serial memory
`timescale 1ns/100ps

package snmcp_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_SR_READ = 8'h05;
  localparam logic [7:0] OP_SR_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // ----------------------------------------------------------------
  // Array geometry and protection ranges
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 8192;
  localparam logic [12:0] ADDR_TOP = 13'h1FFF;
  localparam logic [12:0] ADDR_ZERO = 13'h0000;
  localparam logic [12:0] ADDR_STEP = 13'h0001;
  localparam logic [12:0] PROT_QTR_BASE = 13'h1800;
  localparam logic [12:0] PROT_HALF_BASE = 13'h1000;

  // ----------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------
  localparam int BIT_PROTECT_PIN_EN = 7;
  localparam int BIT_BLOCK_HI = 3;
  localparam int BIT_BLOCK_LO = 2;
  localparam int BIT_WRITE_EN = 1;
  localparam logic [2:0] ZERO_FILL = 3'h0;
  localparam logic NV_PIN_EN_RST = 1'b0;
  localparam logic [1:0] NV_BLOCK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_MEM_WR, PH_MEM_RD, PH_SR_WR, PH_SR_RD, PH_IGNORE
  } snmcp_phase_t;

  function automatic logic snmcp_is_protected(input logic [1:0] bp, input logic [12:0] addr);
    case (bp)
      2'h0: return 1'b0;
      2'h1: return addr >= PROT_QTR_BASE;
      2'h2: return addr >= PROT_HALF_BASE;
      default: return 1'b1;
    endcase
  endfunction
endpackage

module snmcp_mem import snmcp_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = MEM_DEPTH
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_arr [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("snmcp_mem: depth or width out of range");
  end

  // Contents have no reset: the array keeps its data like the real cells
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_arr[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_reg <= mem_arr[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;
endmodule

/* snmcp_spi_target.sv */
// SPI target command logic: opcodes, latch, status register and block protection
`timescale 1ns/100ps

module snmcp_spi_target import snmcp_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_oe,
  output logic spi_mode3
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic por;
    logic [2:0] wp_sh;
    logic [2:0] cs_sh;
    logic [2:0] sck_sh;
    logic wp_lvl;
    logic cs_lvl;
    logic sck_lvl;
    logic mode3;
  } snmcp_sys_t;

  typedef struct packed {
    snmcp_phase_t phase;
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [12:0] addr;
    logic is_write;
    logic started;
    logic load_sr;
    logic load_mem;
  } snmcp_frame_t;

  typedef struct packed {
    logic write_enable_flag;
    logic clr_pend;
    logic pin_en;
    logic [1:0] block;
    logic wp_meta;
    logic wp_sync;
  } snmcp_keep_t;

  typedef struct packed {
    logic [7:0] sh;
    logic oe;
  } snmcp_out_t;

  localparam snmcp_sys_t SYS_RST = '{por: 1'b1, wp_sh: 3'h7, cs_sh: 3'h7, sck_sh: 3'h0,
    wp_lvl: 1'b1, cs_lvl: 1'b1, sck_lvl: 1'b0, mode3: 1'b0};
  localparam snmcp_frame_t FRAME_RST = '{phase: PH_OPCODE, bit_cnt: BIT_FIRST, shift: 7'h00,
    addr: ADDR_ZERO, is_write: 1'b0, started: 1'b0, load_sr: 1'b0, load_mem: 1'b0};
  localparam snmcp_keep_t KEEP_RST = '{write_enable_flag: 1'b0, clr_pend: 1'b0, pin_en: NV_PIN_EN_RST,
    block: NV_BLOCK_RST, wp_meta: 1'b1, wp_sync: 1'b1};
  localparam snmcp_out_t OUT_RST = '{sh: 8'h00, oe: 1'b0};

  snmcp_sys_t sy_reg, sy_next;
  snmcp_frame_t fr_reg, fr_next;
  snmcp_keep_t kp_reg, kp_next;
  snmcp_out_t ot_reg, ot_next;

  logic [7:0] byte_in;
  logic byte_done;
  logic wel_now;
  logic sr_locked;
  logic op_set_hit;
  logic mem_we;
  logic [12:0] mem_waddr;
  logic mem_re;
  logic [12:0] mem_raddr;
  logic [12:0] addr_full;
  logic [7:0] mem_rdata;
  logic [7:0] status_byte;

  // ----------------------------------------------------------------
  // System clock side: power-up reset and pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    sy_next = sy_reg;
    sy_next.por = 1'b0;
    sy_next.wp_sh = {sy_reg.wp_sh[1:0], write_protect_n};
    sy_next.cs_sh = {sy_reg.cs_sh[1:0], chip_select_n};
    sy_next.sck_sh = {sy_reg.sck_sh[1:0], spi_clk};
    if (sy_reg.wp_sh[1] == sy_reg.wp_sh[2]) begin
      sy_next.wp_lvl = sy_reg.wp_sh[2];
    end
    if (sy_reg.sck_sh[1] == sy_reg.sck_sh[2]) begin
      sy_next.sck_lvl = sy_reg.sck_sh[2];
    end
    if (sy_reg.cs_sh[1] == sy_reg.cs_sh[2]) begin
      sy_next.cs_lvl = sy_reg.cs_sh[2];
      if (sy_reg.cs_lvl && !sy_reg.cs_sh[2]) begin
        sy_next.mode3 = sy_reg.sck_lvl;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sy_reg <= SYS_RST;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign spi_mode3 = sy_reg.mode3;

  // ----------------------------------------------------------------
  // Link side: command decode on rising serial clock
  // ----------------------------------------------------------------
  assign byte_in = {fr_reg.shift, serial_in};
  assign byte_done = (fr_reg.bit_cnt == BIT_LAST);
  assign addr_full = {fr_reg.addr[12:8], byte_in};
  // A clear left armed by the previous frame takes effect on this frame's first edge
  assign wel_now = kp_reg.write_enable_flag & ~(kp_reg.clr_pend & ~fr_reg.started);
  assign sr_locked = kp_reg.pin_en & ~kp_reg.wp_sync;
  assign op_set_hit = (fr_reg.phase == PH_OPCODE) && byte_done && (byte_in == OP_SET_LATCH);
  assign status_byte = {kp_reg.pin_en, ZERO_FILL, kp_reg.block, kp_reg.write_enable_flag, 1'b0};

  always_comb begin
    fr_next = fr_reg;
    kp_next = kp_reg;
    mem_we = 1'b0;
    mem_waddr = fr_reg.addr;
    mem_re = 1'b0;
    mem_raddr = fr_reg.addr;
    fr_next.bit_cnt = fr_reg.bit_cnt + BIT_STEP;
    fr_next.shift = byte_in[6:0];
    fr_next.started = 1'b1;
    fr_next.load_sr = 1'b0;
    fr_next.load_mem = 1'b0;
    kp_next.wp_meta = sy_reg.wp_lvl;
    kp_next.wp_sync = kp_reg.wp_meta;
    if (kp_reg.clr_pend && !fr_reg.started) begin
      kp_next.write_enable_flag = 1'b0;
      kp_next.clr_pend = 1'b0;
    end
    if (byte_done) begin
      case (fr_reg.phase)
        PH_OPCODE: begin
          fr_next.phase = PH_IGNORE;
          case (byte_in)
            OP_SET_LATCH: begin
              kp_next.write_enable_flag = 1'b1;
            end
            OP_CLR_LATCH: begin
              kp_next.write_enable_flag = 1'b0;
              kp_next.clr_pend = 1'b1;
            end
            OP_SR_READ: begin
              fr_next.phase = PH_SR_RD;
              fr_next.load_sr = 1'b1;
            end
            OP_SR_WRITE: begin
              fr_next.phase = PH_SR_WR;
              kp_next.clr_pend = 1'b1;
            end
            OP_MEM_READ: begin
              fr_next.phase = PH_ADDR_HI;
              fr_next.is_write = 1'b0;
            end
            OP_MEM_WRITE: begin
              fr_next.phase = PH_ADDR_HI;
              fr_next.is_write = 1'b1;
              kp_next.clr_pend = 1'b1;
            end
            default: begin
              fr_next.phase = PH_IGNORE;
            end
          endcase
        end
        PH_ADDR_HI: begin
          fr_next.addr = {byte_in[4:0], 8'h00};
          fr_next.phase = PH_ADDR_LO;
        end
        PH_ADDR_LO: begin
          if (fr_reg.is_write) begin
            fr_next.addr = addr_full;
            fr_next.phase = PH_MEM_WR;
          end else begin
            // Fetch issued here so the first bit is ready at the next falling edge
            mem_re = 1'b1;
            mem_raddr = addr_full;
            fr_next.addr = addr_full + ADDR_STEP;
            fr_next.load_mem = 1'b1;
            fr_next.phase = PH_MEM_RD;
          end
        end
        PH_MEM_WR: begin
          mem_we = wel_now && !snmcp_is_protected(kp_reg.block, fr_reg.addr);
          fr_next.addr = fr_reg.addr + ADDR_STEP;
        end
        PH_MEM_RD: begin
          mem_re = 1'b1;
          fr_next.addr = fr_reg.addr + ADDR_STEP;
          fr_next.load_mem = 1'b1;
        end
        PH_SR_WR: begin
          if (wel_now && !sr_locked) begin
            kp_next.pin_en = byte_in[BIT_PROTECT_PIN_EN];
            kp_next.block = {byte_in[BIT_BLOCK_HI], byte_in[BIT_BLOCK_LO]};
          end
          fr_next.phase = PH_IGNORE;
        end
        default: begin
          fr_next.phase = PH_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      fr_reg <= FRAME_RST;
    end else begin
      fr_reg <= fr_next;
    end
  end

  always_ff @(posedge spi_clk or posedge sy_reg.por) begin
    if (sy_reg.por) begin
      kp_reg <= KEEP_RST;
    end else begin
      kp_reg <= kp_next;
    end
  end

  snmcp_mem #(
    .WIDTH(DATA_W),
    .DEPTH(MEM_DEPTH)
  ) u_mem (
    .clk(spi_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(byte_in),
    .rd_en(mem_re),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Link side: output shifter on falling serial clock
  // ----------------------------------------------------------------
  always_comb begin
    ot_next = ot_reg;
    ot_next.sh = {ot_reg.sh[6:0], 1'b0};
    if (fr_reg.load_sr) begin
      ot_next.sh = status_byte;
      ot_next.oe = 1'b1;
    end else if (fr_reg.load_mem) begin
      ot_next.sh = mem_rdata;
      ot_next.oe = 1'b1;
    end
  end

  always_ff @(negedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      ot_reg <= OUT_RST;
    end else begin
      ot_reg <= ot_next;
    end
  end

  assign serial_out = ot_reg.sh[7];
  assign serial_out_oe = ot_reg.oe & ~chip_select_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_byte_start;
    fr_reg.phase == PH_MEM_WR && fr_reg.bit_cnt == BIT_FIRST && wel_now
      && kp_reg.block == 2'h0;
  endsequence

  sequence s_byte_commit;
    ##7 mem_we && mem_waddr == $past(fr_reg.addr, 7);
  endsequence

  property p_byte_commit;
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      s_wr_byte_start |-> s_byte_commit;
  endproperty

  a_byte_commit_time: assert property (p_byte_commit)
    else $error("byte not committed at its eighth bit");

  a_status_read_load: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      (fr_reg.phase == PH_OPCODE && byte_done && byte_in == OP_SR_READ)
      |=> fr_reg.load_sr && fr_reg.phase == PH_SR_RD)
    else $error("status read opcode did not load status");

  a_latch_set_cmd: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      op_set_hit |=> (kp_reg.write_enable_flag && !kp_reg.clr_pend))
    else $error("set opcode did not set latch");

  a_latch_only_set: assert property (
    @(posedge spi_clk) disable iff (sy_reg.por)
      $rose(kp_reg.write_enable_flag) |-> $past(op_set_hit))
    else $error("latch set without set opcode");

  a_array_write_gate: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      mem_we |-> wel_now && !snmcp_is_protected(kp_reg.block, mem_waddr))
    else $error("array written while latch clear or range protected");

  a_addr_wrap_zero: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      (fr_reg.phase == PH_MEM_WR && byte_done && fr_reg.addr == ADDR_TOP)
      |=> fr_reg.addr == ADDR_ZERO)
    else $error("address did not wrap to zero");

  a_status_pin_lock: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      (fr_reg.phase == PH_SR_WR && byte_done && sr_locked)
      |-> kp_next.pin_en == kp_reg.pin_en && kp_next.block == kp_reg.block)
    else $error("status written while protect pin active");

  a_wel_write_kept: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      (fr_reg.phase == PH_SR_WR && byte_done) |-> kp_next.write_enable_flag == wel_now)
    else $error("status write changed latch");

  a_unknown_quiet: assert property (
    @(posedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      (fr_reg.phase == PH_OPCODE && byte_done && byte_in[7:3] != 5'h00)
      |=> (!serial_out_oe)[*8])
    else $error("output driven after unknown opcode");

  a_status_shift_out: assert property (
    @(negedge spi_clk) disable iff (chip_select_n || sy_reg.por)
      fr_reg.load_sr |=> ot_reg.sh == $past(status_byte) && serial_out_oe)
    else $error("status byte not loaded on falling edge");

endmodule

/* snmcp_host.sv */
// Host-side SPI controller model that drives the serial memory target
`timescale 1ns/100ps

module snmcp_host (
  output logic spi_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic mode3;
  logic oe_seen;

  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b0;
    serial_in = 1'b0;
    mode3 = 1'b0;
    oe_seen = 1'b0;
    // A real rising edge on select clears the frame logic, which has no other reset
    #10;
    chip_select_n = 1'b1;
  end

  task automatic start(input logic m3);
    mode3 = m3;
    spi_clk = m3;
    // Idle level holds five system clocks around select fall for the mode sampler
    #200;
    chip_select_n = 1'b0;
    oe_seen = 1'b0;
    #200;
  endtask

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_clk = 1'b0;
      serial_in = tx[i];
      #15;
      rx[i] = serial_out;
      oe_seen = oe_seen | serial_out_oe;
      spi_clk = 1'b1;
      #15;
    end
  endtask

  task automatic stop();
    if (!mode3) begin
      spi_clk = 1'b0;
    end
    #15;
    chip_select_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_in = ~serial_in;
    #100;
  endtask
endmodule

/* tb_top.sv */
// Self-checking testbench for the serial memory target command logic
`timescale 1ns/100ps

`define CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH %s expected %h seen %h", name, exp, got); \
    end \
  end

module tb_top import snmcp_pkg::*;;
  logic clk_sys;
  logic sys_rst;
  logic write_protect_n;
  logic spi_clk;
  logic chip_select_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic spi_mode3;
  int bad_count = 0;
  int n_checks = 0;

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  snmcp_spi_target i_snmcp_spi_target (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .write_protect_n(write_protect_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .spi_mode3(spi_mode3)
  );

  snmcp_host i_snmcp_host (
    .spi_clk(spi_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );

  // ----------------------------------------------------------------
  // Frame helpers
  // ----------------------------------------------------------------
  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    i_snmcp_host.start(1'b0);
    i_snmcp_host.xbyte(op, rx);
    i_snmcp_host.stop();
  endtask

  task automatic sr_rd(input logic m3, input logic [7:0] exp, input string what);
    logic [7:0] rx;
    i_snmcp_host.start(m3);
    i_snmcp_host.xbyte(OP_SR_READ, rx);
    i_snmcp_host.xbyte(8'h00, rx);
    i_snmcp_host.stop();
    `CHK(what, exp, rx)
    // Mode flag crosses into the system domain, give it a few cycles
    repeat (4) @(posedge clk_sys);
    `CHK("clock mode", m3, spi_mode3)
  endtask

  task automatic sr_wr(input logic [7:0] v);
    logic [7:0] rx;
    cmd(OP_SET_LATCH);
    i_snmcp_host.start(1'b0);
    i_snmcp_host.xbyte(OP_SR_WRITE, rx);
    i_snmcp_host.xbyte(v, rx);
    i_snmcp_host.stop();
  endtask

  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d [$], input logic latch);
    logic [7:0] rx;
    if (latch) begin
      cmd(OP_SET_LATCH);
    end
    i_snmcp_host.start(1'b0);
    i_snmcp_host.xbyte(OP_MEM_WRITE, rx);
    i_snmcp_host.xbyte(a[15:8], rx);
    i_snmcp_host.xbyte(a[7:0], rx);
    foreach (d[i]) begin
      i_snmcp_host.xbyte(d[i], rx);
    end
    i_snmcp_host.stop();
  endtask

  task automatic mem_rd(input logic [15:0] a, input logic [7:0] e [$], input logic m3,
                        input string what);
    logic [7:0] rx;
    i_snmcp_host.start(m3);
    i_snmcp_host.xbyte(OP_MEM_READ, rx);
    i_snmcp_host.xbyte(a[15:8], rx);
    i_snmcp_host.xbyte(a[7:0], rx);
    foreach (e[i]) begin
      // Input carries junk during data bytes; it must be ignored
      i_snmcp_host.xbyte(~e[i], rx);
      `CHK(what, e[i], rx)
    end
    `CHK("read drive", 1'b1, i_snmcp_host.oe_seen)
    i_snmcp_host.stop();
  endtask

  task automatic set_wp(input logic v);
    @(posedge clk_sys);
    write_protect_n <= v;
    repeat (6) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK("idle drive", 1'b0, serial_out_oe)
    sr_rd(1'b0, 8'h00, "status after reset");
    $display("test reset done");
  endtask

  task automatic t_latch();
    logic [7:0] rx;
    cmd(OP_SET_LATCH);
    sr_rd(1'b1, 8'h02, "latch set");
    cmd(OP_CLR_LATCH);
    sr_rd(1'b0, 8'h00, "latch cleared");
    i_snmcp_host.start(1'b0);
    i_snmcp_host.xbyte(OP_SET_LATCH, rx);
    i_snmcp_host.xbyte(OP_CLR_LATCH, rx);
    i_snmcp_host.stop();
    sr_rd(1'b0, 8'h02, "second opcode");
    cmd(OP_CLR_LATCH);
    $display("test latch done");
  endtask

  task automatic t_status();
    sr_wr(8'hFF);
    sr_rd(1'b0, 8'h8C, "status all ones");
    set_wp(1'b0);
    sr_wr(8'h00);
    sr_rd(1'b0, 8'h8C, "status pin locked");
    set_wp(1'b1);
    sr_wr(8'h00);
    sr_rd(1'b1, 8'h00, "status pin free");
    $display("test status done");
  endtask

  task automatic t_mem();
    mem_wr(16'hFFFE, '{8'h11, 8'hA5, 8'h3C}, 1'b1);
    mem_rd(16'h1FFE, '{8'h11, 8'hA5, 8'h3C}, 1'b1, "wrap data");
    sr_rd(1'b0, 8'h00, "latch after write");
    mem_wr(16'h1FFE, '{8'h77}, 1'b0);
    mem_rd(16'hFFFF, '{8'hA5, 8'h3C}, 1'b0, "upper bits ignored");
    mem_rd(16'h1FFE, '{8'h11}, 1'b0, "write without latch");
    $display("test memory done");
  endtask

  task automatic t_protect();
    logic [7:0] e [4];
    logic [7:0] v;
    e = '{8'h00, 8'h01, 8'h02, 8'h03};
    // Pin low with its enable clear: both status and array writes go ahead
    set_wp(1'b0);
    mem_wr(16'h0FFF, '{e[0], e[1]}, 1'b1);
    mem_wr(16'h17FF, '{e[2], e[3]}, 1'b1);
    for (int bp = 1; bp < 4; bp++) begin
      sr_wr({4'h0, bp[1:0], 2'h0});
      sr_rd(1'b0, {4'h0, bp[1:0], 2'h0}, "block bits");
      v = 8'(bp * 16);
      mem_wr(16'h0FFF, '{v, v + 8'h01}, 1'b1);
      mem_wr(16'h17FF, '{v + 8'h02, v + 8'h03}, 1'b1);
      if (bp < 3) begin
        e[0] = v;
      end
      if (bp < 2) begin
        e[1] = v + 8'h01;
        e[2] = v + 8'h02;
      end
      mem_rd(16'h0FFF, '{e[0], e[1]}, 1'b0, "lower range");
      mem_rd(16'h17FF, '{e[2], e[3]}, 1'b0, "upper range");
    end
    sr_wr(8'h00);
    set_wp(1'b1);
    $display("test protect done");
  endtask

  task automatic t_unknown();
    logic [7:0] rx;
    i_snmcp_host.start(1'b0);
    i_snmcp_host.xbyte(8'hA7, rx);
    i_snmcp_host.xbyte(OP_SR_READ, rx);
    i_snmcp_host.xbyte(8'h00, rx);
    `CHK("unknown drive", 1'b0, i_snmcp_host.oe_seen)
    i_snmcp_host.stop();
    $display("test unknown done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    write_protect_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Protect pin synchroniser settles before the first frame
    repeat (7) @(posedge clk_sys);
    t_reset();
    t_latch();
    t_status();
    t_mem();
    t_protect();
    t_unknown();
    report_and_stop();
  end

  // Run needs well under a quarter of this span
  initial begin
    #1000000;
    bad_count++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
